// ==== hdl/pdcl_pkg.sv ====
// constants, types and register map of the passenger door control logic
// Function
// - Passenger-opened door recloses after reclose delay
// - Delay expiry starts four second closing cycle
// - Reclose delay adjustable in four second steps
// - Passenger buttons only ever open doors
// - Station commands go out on trainlines
// - Station commands only while activation switch on
// - Enable button enables same-side passenger buttons
// - Passenger open needs enable; lamp shows enable
// - Hold end: warn, close, stay enabled
// - Station close button cancels passenger enable
// - Green lamp only when all doors but a held leaf closed
// - Leaf hold works only with station active
// - Leaf hold keeps green lamp lit
// - Active station amber dark, others flash
// - Single-leaf button opens nearest leaf only
// - No interlock while release relay energized
// - Staff key needs zero speed, breaks interlock
// - Pull ring opens side doors under power
// - Pull ring inhibits closing until manual reset
// - Side mapping follows car orientation
// - Every input and output visible on indicators
// - No zero speed nor bypass: refuse opening, except by pull ring
// - Single leaf stays open until close/speed
// - Active station shorts opposite open trainline
package pdcl_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES_DEF = TICK_MS * 1000 * CLK_MHZ;
  localparam int DEB_MS = 10;
  localparam int DEB_CYCLES_DEF = DEB_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam int RECLOSE_MS = 15000;
  localparam int RECLOSE_TICKS = RECLOSE_MS / TICK_MS;
  localparam int STEP_MS = 4000;
  localparam int STEP_TICKS = STEP_MS / TICK_MS;
  localparam int CLOSE_MS = 4000;
  localparam int CLOSE_TICKS = CLOSE_MS / TICK_MS;
  localparam int WARN_MS = 1000;
  localparam int WARN_TICKS = WARN_MS / TICK_MS;
  localparam int FLASH_MS = 500;
  localparam int FLASH_TICKS = FLASH_MS / TICK_MS;
  localparam int TMR_W = 9;

  // ****************************************
  // registers
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] IN_LO_OFS = 8'h04;
  localparam logic [7:0] IN_HI_OFS = 8'h08;
  localparam logic [7:0] OUT_OFS = 8'h0C;
  localparam int CTRL_STEP_LSB = 0;
  localparam int CTRL_REV_BIT = 3;
  localparam int CTRL_REAR_BIT = 4;
  localparam logic [2:0] STEP_RST = 3'h0;
  localparam logic [2:0] STEP_MIN_BAD = 3'h4;
  localparam logic [2:0] STEP_MIN = 3'h5;
  localparam logic REV_RST = 1'h0;
  localparam logic REAR_RST = 1'h0;

  localparam int NUM_IN = 44;
  localparam int NUM_OUT = 28;

  typedef enum logic [1:0] {
    DOOR_CLOSED = 2'h0,
    DOOR_OPENED = 2'h1,
    DOOR_WARN = 2'h3,
    DOOR_CLOSING = 2'h2
  } pdcl_door_e;

endpackage

// ==== hdl/pdcl_debounce.sv ====
// two-stage synchroniser and sampled debouncer for a vector of pins
`timescale 1ns/1ns
module pdcl_debounce #(
  parameter int W = 8,
  parameter int DEB_CYCLES = 1000
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] samp;
    logic [W-1:0] stable;
    logic [pdcl_pkg::CNT_W-1:0] cnt;
  } pdcl_deb_s;

  pdcl_deb_s r;
  pdcl_deb_s next_r;
  logic [W-1:0] eq;

  assign eq = ~(r.s2 ^ r.samp);
  assign clean = r.stable;

  always_comb begin
    next_r = r;
    next_r.s1 = raw;
    next_r.s2 = r.s1;
    if (r.cnt == '0) begin
      next_r.cnt = pdcl_pkg::CNT_W'(DEB_CYCLES - 1);
      next_r.samp = r.s2;
      // a bit changes only after two equal samples one period apart
      next_r.stable = (eq & r.s2) | (~eq & r.stable);
    end else begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

// ==== hdl/pdcl_tick.sv ====
// prescaler giving a one-cycle tick enable
`timescale 1ns/1ns
module pdcl_tick #(
  parameter int CYCLES = 1000
) (
  input wire logic clock,
  input wire logic rst,
  output logic tick
);

  typedef struct packed {
    logic [pdcl_pkg::CNT_W-1:0] cnt;
    logic tick;
  } pdcl_tick_s;

  pdcl_tick_s r;
  pdcl_tick_s next_r;

  assign tick = r.tick;

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.cnt == '0) begin
      next_r.cnt = pdcl_pkg::CNT_W'(CYCLES - 1);
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

// ==== hdl/pdcl_top.sv ====
// car side door controller with APB status and control registers
`timescale 1ns/1ns
module pdcl_top #(
  parameter int TICK_CYCLES = pdcl_pkg::TICK_CYCLES_DEF,
  parameter int DEB_CYCLES = pdcl_pkg::DEB_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] stationOn,
  input wire logic [1:0] openFwd,
  input wire logic [1:0] openRear,
  input wire logic [1:0] closeFwd,
  input wire logic [1:0] closeRear,
  input wire logic [1:0] enablePb,
  input wire logic [1:0] crewOpen,
  input wire logic [1:0] crewHold,
  input wire logic [1:0] paxIn,
  input wire logic [1:0] paxOut,
  input wire logic [1:0] staffKey,
  input wire logic [1:0] pullRing,
  input wire logic [1:0] ringReset,
  input wire logic [1:0] doorClosedSw,
  input wire logic [1:0] leafClosedSw,
  input wire logic [1:0] tlOpenFwdIn,
  input wire logic [1:0] tlOpenRearIn,
  input wire logic [1:0] tlCloseFwdIn,
  input wire logic [1:0] tlCloseRearIn,
  input wire logic [1:0] tlEnableIn,
  input wire logic tlStationIn,
  input wire logic tlAllClosedIn,
  input wire logic zeroSpeed,
  input wire logic zeroBypass,
  output logic [1:0] doorOpen,
  output logic [1:0] crewLeafOpen,
  output logic [1:0] closeWarn,
  output logic [1:0] paxLamp,
  output logic [1:0] greenLamp,
  output logic [1:0] amberLamp,
  output logic [1:0] releaseRelay,
  output logic [1:0] tlOpenFwdOut,
  output logic [1:0] tlOpenRearOut,
  output logic [1:0] tlCloseFwdOut,
  output logic [1:0] tlCloseRearOut,
  output logic [1:0] tlEnableOut,
  output logic [1:0] tlOpenShort,
  output logic tlStationOut,
  output logic carInterlock,
  output logic [71:0] ioLeds
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    pdcl_pkg::pdcl_door_e [1:0] door;
    logic [1:0][pdcl_pkg::TMR_W-1:0] tmr;
    logic [1:0] pax;
    logic [1:0] enabled;
    logic [1:0] crewLeaf;
    logic [1:0] ring;
    logic [2:0] flashCnt;
    logic flash;
    logic [2:0] step;
    logic rev;
    logic rearGrp;
    logic [31:0] rdata;
    logic err;
    logic [pdcl_pkg::NUM_OUT-1:0] outs;
  } pdcl_top_s;

  pdcl_top_s r;
  pdcl_top_s next_r;

  logic [pdcl_pkg::NUM_IN-1:0] din;
  logic tick;
  logic [1:0] dStationOn, dOpenFwd, dOpenRear, dCloseFwd, dCloseRear;
  logic [1:0] dEnablePb, dCrewOpen, dCrewHold, dPaxIn, dPaxOut;
  logic [1:0] dStaffKey, dPullRing, dRingReset, dDoorClosedSw, dLeafClosedSw;
  logic [1:0] dTlOpenFwdIn, dTlOpenRearIn, dTlCloseFwdIn, dTlCloseRearIn;
  logic [1:0] dTlEnableIn;
  logic dTlStationIn, dTlAllClosedIn, dZeroSpeed, dZeroBypass;

  // ****************************************
  // input conditioning
  // ****************************************
  pdcl_debounce #(
    .W(pdcl_pkg::NUM_IN),
    .DEB_CYCLES(DEB_CYCLES)
  ) u_deb (
    .clock(clock),
    .rst(rst),
    .raw({zeroBypass, zeroSpeed, tlAllClosedIn, tlStationIn, tlEnableIn,
          tlCloseRearIn, tlCloseFwdIn, tlOpenRearIn, tlOpenFwdIn,
          leafClosedSw, doorClosedSw, ringReset, pullRing, staffKey,
          paxOut, paxIn, crewHold, crewOpen, enablePb, closeRear,
          closeFwd, openRear, openFwd, stationOn}),
    .clean(din)
  );

  assign {dZeroBypass, dZeroSpeed, dTlAllClosedIn, dTlStationIn, dTlEnableIn,
          dTlCloseRearIn, dTlCloseFwdIn, dTlOpenRearIn, dTlOpenFwdIn,
          dLeafClosedSw, dDoorClosedSw, dRingReset, dPullRing, dStaffKey,
          dPaxOut, dPaxIn, dCrewHold, dCrewOpen, dEnablePb, dCloseRear,
          dCloseFwd, dOpenRear, dOpenFwd, dStationOn} = din;

  pdcl_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock(clock),
    .rst(rst),
    .tick(tick)
  );

  // ****************************************
  // side mapping
  // ****************************************
  // car side and trainline side are equal, or swapped for a turned car
  function automatic logic [1:0] swap2(input logic [1:0] v, input logic rev);
    swap2 = rev ? {v[0], v[1]} : v;
  endfunction

  logic zsOk;
  logic [1:0] staffOpen, holdAct, enableCar, paxReq, openReq, closeReq;
  logic [1:0] outOpenFwd, outOpenRear, outCloseFwd, outCloseRear, outEnable;
  logic [1:0] shortTl, openFwdCar, openRearCar, grpOpen, grpClose;
  logic [1:0] cDoorOpen, cWarn, tmrEnd, leafOut, relay, green, amber;
  logic carIlk, mainsOk;
  logic [pdcl_pkg::TMR_W-1:0] recDelay;
  logic [31:0] ctrlWord;

  assign zsOk = dZeroSpeed | dZeroBypass;
  // staff key gated by zero speed
  assign staffOpen = dStaffKey & {2{dZeroSpeed}};
  assign holdAct = dCrewHold & dStationOn;

  assign outOpenFwd = swap2(dStationOn & dOpenFwd, r.rev);
  assign outOpenRear = swap2(dStationOn & dOpenRear, r.rev);
  assign outCloseFwd = swap2(dStationOn & dCloseFwd, r.rev);
  assign outCloseRear = swap2(dStationOn & dCloseRear, r.rev);
  assign outEnable = swap2(dStationOn & dEnablePb, r.rev);
  assign shortTl = swap2({dStationOn[0], dStationOn[1]}, r.rev);

  assign openFwdCar = swap2((dTlOpenFwdIn | outOpenFwd) & ~shortTl, r.rev);
  assign openRearCar = swap2((dTlOpenRearIn | outOpenRear) & ~shortTl, r.rev);
  // group commands act on this car
  assign grpOpen = r.rearGrp ? openRearCar : openFwdCar;
  assign grpClose = r.rearGrp ? swap2(dTlCloseRearIn | outCloseRear, r.rev)
                              : swap2(dTlCloseFwdIn | outCloseFwd, r.rev);
  // enable trainline for the whole side
  assign enableCar = swap2(dTlEnableIn | outEnable, r.rev);

  assign openReq = ({2{zsOk}} & grpOpen) | staffOpen;
  assign paxReq = {2{zsOk}} & r.enabled & (dPaxIn | dPaxOut);
  assign closeReq = grpClose | {2{~zsOk}};

  assign recDelay = pdcl_pkg::TMR_W'(pdcl_pkg::RECLOSE_TICKS
                    + $signed(r.step) * pdcl_pkg::STEP_TICKS);

  // ****************************************
  // per side status
  // ****************************************
  for (genvar s = 0; s < 2; s++) begin : g_side
    assign cDoorOpen[s] = (r.door[s] == pdcl_pkg::DOOR_OPENED)
                          || (r.door[s] == pdcl_pkg::DOOR_WARN);
    assign cWarn[s] = (r.door[s] == pdcl_pkg::DOOR_WARN)
                      || (r.door[s] == pdcl_pkg::DOOR_CLOSING);
    assign tmrEnd[s] = tick && (r.tmr[s] <= pdcl_pkg::TMR_W'(1));
    assign leafOut[s] = r.crewLeaf[s] | cDoorOpen[s];
    // held leaf ignored for the lamp
    assign green[s] = dTlAllClosedIn
                      & (carIlk | (holdAct[s] & mainsOk & dLeafClosedSw[1 - s]));
    assign amber[s] = ~dStationOn[s] & (dTlStationIn | (|dStationOn)) & r.flash;
  end

  assign relay = cDoorOpen | r.crewLeaf;
  assign mainsOk = (&dDoorClosedSw) & ~(|dStaffKey);
  assign carIlk = mainsOk & (&dLeafClosedSw) & ~(|relay);

  assign ctrlWord = 32'({r.rearGrp, r.rev, r.step});

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_r = r;
    for (int s = 0; s < 2; s++) begin
      case (r.door[s])
        pdcl_pkg::DOOR_CLOSED: begin
          if (r.ring[s] || openReq[s]) begin
            next_r.door[s] = pdcl_pkg::DOOR_OPENED;
            next_r.pax[s] = 1'b0;
          end else if (paxReq[s]) begin
            next_r.door[s] = pdcl_pkg::DOOR_OPENED;
            next_r.pax[s] = 1'b1;
            next_r.tmr[s] = recDelay;
          end
        end
        pdcl_pkg::DOOR_OPENED: begin
          if (r.ring[s] || openReq[s]) begin
            next_r.pax[s] = 1'b0;
          end else if (closeReq[s] || (r.pax[s] && tmrEnd[s])) begin
            next_r.door[s] = pdcl_pkg::DOOR_WARN;
            next_r.tmr[s] = pdcl_pkg::TMR_W'(pdcl_pkg::WARN_TICKS);
          end else if (r.pax[s] && tick) begin
            next_r.tmr[s] = r.tmr[s] - 1'b1;
          end
        end
        pdcl_pkg::DOOR_WARN: begin
          if (r.ring[s] || openReq[s]) begin
            next_r.door[s] = pdcl_pkg::DOOR_OPENED;
            next_r.pax[s] = 1'b0;
          end else if (tmrEnd[s]) begin
            next_r.door[s] = pdcl_pkg::DOOR_CLOSING;
            next_r.tmr[s] = pdcl_pkg::TMR_W'(pdcl_pkg::CLOSE_TICKS);
          end else if (tick) begin
            next_r.tmr[s] = r.tmr[s] - 1'b1;
          end
        end
        pdcl_pkg::DOOR_CLOSING: begin
          if (r.ring[s] || openReq[s]) begin
            next_r.door[s] = pdcl_pkg::DOOR_OPENED;
            next_r.pax[s] = 1'b0;
          end else if (paxReq[s]) begin
            next_r.door[s] = pdcl_pkg::DOOR_OPENED;
            next_r.pax[s] = 1'b1;
            next_r.tmr[s] = recDelay;
          end else if (tmrEnd[s]) begin
            next_r.door[s] = pdcl_pkg::DOOR_CLOSED;
          end else if (tick) begin
            next_r.tmr[s] = r.tmr[s] - 1'b1;
          end
        end
        default: begin
          next_r.door[s] = pdcl_pkg::DOOR_CLOSED;
        end
      endcase

      next_r.ring[s] = dPullRing[s] | (r.ring[s] & ~dRingReset[s]);
      next_r.enabled[s] = enableCar[s] | (r.enabled[s] & ~grpClose[s]);
      // single leaf open, kept until close or speed
      next_r.crewLeaf[s] = (dCrewOpen[s] & dStationOn[s] & zsOk)
                           | (holdAct[s] & cDoorOpen[s])
                           | (r.crewLeaf[s] & (holdAct[s]
                              | ~(grpClose[s] | ~zsOk)));
    end

    if (tick) begin
      if (r.flashCnt == 3'h0) begin
        next_r.flashCnt = 3'(pdcl_pkg::FLASH_TICKS - 1);
        next_r.flash = ~r.flash;
      end else begin
        next_r.flashCnt = r.flashCnt - 1'b1;
      end
    end

    next_r.outs = {carIlk, |dStationOn, shortTl, outEnable, outCloseRear,
                   outCloseFwd, outOpenRear, outOpenFwd, relay, amber, green,
                   r.enabled, cWarn, leafOut, cDoorOpen};

    // read data and error are caught in the setup phase
    if (psel && !penable) begin
      next_r.err = 1'b0;
      case (paddr)
        pdcl_pkg::CTRL_OFS: begin
          next_r.rdata = ctrlWord;
        end
        pdcl_pkg::IN_LO_OFS: begin
          next_r.rdata = din[31:0];
        end
        pdcl_pkg::IN_HI_OFS: begin
          next_r.rdata = 32'(din[pdcl_pkg::NUM_IN-1:32]);
        end
        pdcl_pkg::OUT_OFS: begin
          next_r.rdata = 32'(r.outs);
        end
        default: begin
          next_r.rdata = 32'h0;
          next_r.err = 1'b1;
        end
      endcase
      if (pwrite && paddr != pdcl_pkg::CTRL_OFS) begin
        next_r.err = 1'b1;
      end
    end
    if (psel && penable && pwrite && paddr == pdcl_pkg::CTRL_OFS) begin
      // a step of -4 would leave under a second, so it saturates at -3
      if (pwdata[2:0] == pdcl_pkg::STEP_MIN_BAD) begin
        next_r.step = pdcl_pkg::STEP_MIN;
      end else begin
        next_r.step = pwdata[pdcl_pkg::CTRL_STEP_LSB +: 3];
      end
      next_r.rev = pwdata[pdcl_pkg::CTRL_REV_BIT];
      next_r.rearGrp = pwdata[pdcl_pkg::CTRL_REAR_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
      r.step <= pdcl_pkg::STEP_RST;
      r.rev <= pdcl_pkg::REV_RST;
      r.rearGrp <= pdcl_pkg::REAR_RST;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pready = 1'b1;
  assign prdata = r.rdata;
  assign pslverr = r.err;
  assign {carInterlock, tlStationOut, tlOpenShort, tlEnableOut, tlCloseRearOut,
          tlCloseFwdOut, tlOpenRearOut, tlOpenFwdOut, releaseRelay, amberLamp,
          greenLamp, paxLamp, closeWarn, crewLeafOpen, doorOpen} = r.outs;
  assign ioLeds = {r.outs, din};

endmodule

// ==== testbench/pdcl_top_sva.sv ====
// port assertions for the door controller
`timescale 1ns/1ns
module pdcl_top_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] doorOpen,
  input wire logic [1:0] closeWarn,
  input wire logic [1:0] greenLamp,
  input wire logic [1:0] amberLamp,
  input wire logic [1:0] releaseRelay,
  input wire logic carInterlock,
  input wire logic [71:0] ioLeds
);
  // ********************
  // properties
  // ********************
  // debounced pins are watched through the led mirror, so counts allow the state and output flops
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_ready_const: assert property (pready)
    else $error("pready dropped");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h0C |-> pslverr)
    else $error("unmapped access answered without error");
  a_ro_write: assert property (psel && penable && pwrite && paddr != 8'h00 |-> pslverr)
    else $error("write outside the control register accepted");
  a_relay_lock: assert property (|releaseRelay && $past(|releaseRelay) |-> !carInterlock)
    else $error("interlock made while release relay energized");
  a_key_lock: assert property ((|ioLeds[21:20]) [*3] |-> !carInterlock)
    else $error("interlock made while staff key used");
  a_ring_open: assert property (ioLeds[23] [*4] |-> doorOpen[1])
    else $error("pull ring did not open doors");
  a_warn_first: assert property ($rose(closeWarn[0]) |-> doorOpen[0])
    else $error("warning began with door already shut");
  a_close_warned: assert property ($fell(doorOpen[0]) |-> closeWarn[0])
    else $error("door closed without warning cycle");
  a_green_closed: assert property (!ioLeds[41] [*4] |-> greenLamp == 2'h0)
    else $error("green lamp lit with train not closed");
  a_amber_own: assert property (ioLeds[0] [*4] |-> !amberLamp[0])
    else $error("own amber lamp lit on active station");
  a_led_mirror: assert property (ioLeds[45:44] == doorOpen)
    else $error("door valve led does not follow output");
endmodule

bind pdcl_top pdcl_top_sva u_sva (.clock, .rst, .paddr, .psel, .penable, .pwrite, .pready,
  .pslverr, .doorOpen, .closeWarn, .greenLamp, .amberLamp, .releaseRelay, .carInterlock,
  .ioLeds);

// ==== testbench/pdcl_far_model.sv ====
// far-side model: leaf switches and a single-car trainline loop
`timescale 1ns/1ns
module pdcl_far_model #(
  parameter int TRAVEL = 20
) (
  input wire logic clock,
  input wire logic [1:0] doorOpen,
  input wire logic [1:0] crewLeafOpen,
  input wire logic [1:0] tlOpenFwdOut,
  input wire logic [1:0] tlOpenRearOut,
  input wire logic [1:0] tlCloseFwdOut,
  input wire logic [1:0] tlCloseRearOut,
  input wire logic [1:0] tlEnableOut,
  input wire logic [1:0] tlOpenShort,
  output logic [1:0] doorClosedSw,
  output logic [1:0] leafClosedSw,
  output logic [1:0] tlOpenFwdIn,
  output logic [1:0] tlOpenRearIn,
  output logic [1:0] tlCloseFwdIn,
  output logic [1:0] tlCloseRearIn,
  output logic [1:0] tlEnableIn
);
  int travel [4] = '{default: TRAVEL};
  logic [3:0] valve;
  // ********************
  // trainline loop
  // ********************
  // lines return
  assign tlOpenFwdIn = tlOpenFwdOut & ~tlOpenShort;
  assign tlOpenRearIn = tlOpenRearOut & ~tlOpenShort;
  assign tlCloseFwdIn = tlCloseFwdOut;
  assign tlCloseRearIn = tlCloseRearOut;
  assign tlEnableIn = tlEnableOut;
  // ********************
  // leaf switches
  // ********************
  // reads closed only once the leaf is home, never at the valve edge
  assign valve = {crewLeafOpen, doorOpen};
  always @(posedge clock) begin
    for (int s = 0; s < 4; s++) begin
      if (valve[s]) begin
        travel[s] <= 0;
      end else if (travel[s] < TRAVEL) begin
        travel[s] <= travel[s] + 1;
      end
    end
  end
  assign doorClosedSw = {travel[1] >= TRAVEL, travel[0] >= TRAVEL};
  assign leafClosedSw = {travel[3] >= TRAVEL, travel[2] >= TRAVEL};
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the door control logic
`timescale 1ns/1ns
module tb;
  localparam int TICKC = 10;
  localparam int DEL = (pdcl_pkg::RECLOSE_TICKS - 3 * pdcl_pkg::STEP_TICKS) * TICKC;
  localparam int WT = pdcl_pkg::WARN_TICKS * TICKC;
  localparam int CT = pdcl_pkg::CLOSE_TICKS * TICKC;
  localparam int OF = 0, CF = 1, EN = 2, CO = 3, PO = 4, PR = 5, RR = 6, PI = 7;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] stationOn = 2'h0, openFwd = 2'h0, openRear = 2'h0, closeFwd = 2'h0;
  logic [1:0] closeRear = 2'h0, enablePb = 2'h0, crewOpen = 2'h0, crewHold = 2'h0;
  logic [1:0] paxIn = 2'h0, paxOut = 2'h0, staffKey = 2'h0, pullRing = 2'h0, ringReset = 2'h0;
  logic tlStationIn = 1'b0, tlAllClosedIn = 1'b1, zeroSpeed = 1'b1, zeroBypass = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, tlStationOut, carInterlock;
  logic [1:0] doorOpen, crewLeafOpen, closeWarn, paxLamp, greenLamp, amberLamp, releaseRelay;
  logic [1:0] tlOpenFwdOut, tlOpenRearOut, tlCloseFwdOut, tlCloseRearOut, tlEnableOut;
  logic [1:0] tlOpenShort, doorClosedSw, leafClosedSw, tlOpenFwdIn, tlOpenRearIn;
  logic [1:0] tlCloseFwdIn, tlCloseRearIn, tlEnableIn;
  logic [71:0] ioLeds;
  int err_count = 0;
  int n_tests = 0;
  int n;

  always #5 clock = ~clock;

  pdcl_top #(.TICK_CYCLES(TICKC), .DEB_CYCLES(4)) dut_u (.clock, .rst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .stationOn, .openFwd, .openRear,
    .closeFwd, .closeRear, .enablePb, .crewOpen, .crewHold, .paxIn, .paxOut, .staffKey,
    .pullRing, .ringReset, .doorClosedSw, .leafClosedSw, .tlOpenFwdIn, .tlOpenRearIn,
    .tlCloseFwdIn, .tlCloseRearIn, .tlEnableIn, .tlStationIn, .tlAllClosedIn, .zeroSpeed,
    .zeroBypass, .doorOpen, .crewLeafOpen, .closeWarn, .paxLamp, .greenLamp, .amberLamp,
    .releaseRelay, .tlOpenFwdOut, .tlOpenRearOut, .tlCloseFwdOut, .tlCloseRearOut,
    .tlEnableOut, .tlOpenShort, .tlStationOut, .carInterlock, .ioLeds);

  pdcl_far_model far_u (.clock, .doorOpen, .crewLeafOpen, .tlOpenFwdOut, .tlOpenRearOut,
    .tlCloseFwdOut, .tlCloseRearOut, .tlEnableOut, .tlOpenShort, .doorClosedSw,
    .leafClosedSw, .tlOpenFwdIn, .tlOpenRearIn, .tlCloseFwdIn, .tlCloseRearIn, .tlEnableIn);

  // ********************
  // helpers
  // ********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic hold(input int c);
    repeat (c) @(posedge clock);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set(input int w, input logic [1:0] v);
    case (w)
      OF: openFwd <= v;
      CF: closeFwd <= v;
      EN: enablePb <= v;
      CO: crewOpen <= v;
      PO: paxOut <= v;
      PR: pullRing <= v;
      RR: ringReset <= v;
      default: paxIn <= v;
    endcase
  endtask

  // long enough for sync and debounce on both edges of the press
  task automatic press(input int w, input logic [1:0] v);
    set(w, v);
    hold(30);
    set(w, 2'h0);
    hold(30);
  endtask

  function automatic logic sg(input int w);
    case (w)
      0: return doorOpen[0];
      1: return closeWarn[0];
      2: return doorOpen[1];
      default: return closeWarn[1];
    endcase
  endfunction

  task automatic waitfor(input int w, input logic lvl, input int lim);
    n = 0;
    while (sg(w) !== lvl && n < lim) begin
      @(posedge clock);
      n++;
    end
    chk(sg(w), lvl);
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_regs();
    apb(1'b0, pdcl_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, pdcl_pkg::CTRL_OFS, 32'h4);
    apb(1'b0, pdcl_pkg::CTRL_OFS, 32'h0);
    chk(rd[2:0], pdcl_pkg::STEP_MIN);
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, pdcl_pkg::IN_LO_OFS, 32'hFFFF);
    chk(er, 1'b1);
    apb(1'b1, pdcl_pkg::CTRL_OFS, 32'h5);
    chk(er, 1'b0);
  endtask

  task automatic t_station();
    int hi;
    press(OF, 2'h1);
    chk(doorOpen, 2'h0);
    stationOn <= 2'h1;
    zeroSpeed <= 1'b0;
    hold(30);
    press(OF, 2'h1);
    chk(doorOpen, 2'h0);
    zeroSpeed <= 1'b1;
    hold(30);
    set(OF, 2'h1);
    hold(30);
    chk(tlOpenFwdOut, 2'h1);
    chk(tlOpenShort, 2'h2);
    chk({tlStationOut, tlEnableOut, tlOpenRearOut}, 5'h10);
    press(OF, 2'h0);
    chk(doorOpen, 2'h1);
    chk(greenLamp[0], 1'b0);
    chk(amberLamp[0], 1'b0);
    hi = 0;
    repeat (120) begin
      @(posedge clock);
      hi += amberLamp[1];
    end
    chk(hi > 0 && hi < 120, 1'b1);
    press(CO, 2'h1);
    chk(crewLeafOpen, 2'h1);
    press(CF, 2'h1);
    waitfor(1, 1'b0, 1000);
    hold(60);
    chk(crewLeafOpen, 2'h0);
    chk(greenLamp[0], 1'b1);
    tlAllClosedIn <= 1'b0;
    hold(30);
    chk(greenLamp, 2'h0);
    tlAllClosedIn <= 1'b1;
    hold(30);
    press(CO, 2'h1);
    chk({crewLeafOpen, doorOpen, greenLamp}, 6'h10);
    crewHold <= 2'h1;
    hold(30);
    chk(greenLamp, 2'h1);
    crewHold <= 2'h0;
  endtask

  task automatic t_pax();
    press(PI, 2'h2);
    chk(doorOpen[1], 1'b0);
    press(EN, 2'h1);
    chk(paxLamp, 2'h1);
    set(PI, 2'h1);
    waitfor(0, 1'b1, 200);
    set(PI, 2'h0);
    chk({releaseRelay[0], carInterlock}, 2'h2);
    waitfor(1, 1'b1, 2000);
    chk(n > DEL - 15 && n < DEL + 15, 1'b1);
    waitfor(0, 1'b0, 500);
    chk(n > WT - 12 && n < WT + 12, 1'b1);
    waitfor(1, 1'b0, 1000);
    chk(n > CT - 12 && n < CT + 12, 1'b1);
    chk(paxLamp[0], 1'b1);
    press(PO, 2'h1);
    chk(doorOpen[0], 1'b1);
    press(CF, 2'h1);
    chk(paxLamp[0], 1'b0);
    waitfor(1, 1'b0, 1000);
  endtask

  task automatic t_key();
    zeroSpeed <= 1'b0;
    staffKey <= 2'h2;
    hold(30);
    chk({doorOpen[1], carInterlock}, 2'h0);
    zeroSpeed <= 1'b1;
    hold(30);
    chk(doorOpen[1], 1'b1);
    staffKey <= 2'h0;
    zeroSpeed <= 1'b0;
    hold(30);
    waitfor(3, 1'b0, 1000);
    hold(60);
    chk(carInterlock, 1'b1);
  endtask

  task automatic t_ring();
    press(PR, 2'h2);
    chk(doorOpen[1], 1'b1);
    hold(700);
    chk(doorOpen[1], 1'b1);
    press(RR, 2'h2);
    zeroSpeed <= 1'b1;
    hold(30);
    zeroSpeed <= 1'b0;
    waitfor(3, 1'b1, 300);
    waitfor(3, 1'b0, 1000);
    chk(doorOpen[1], 1'b0);
  endtask

  task automatic t_rev();
    zeroSpeed <= 1'b1;
    apb(1'b1, pdcl_pkg::CTRL_OFS, 32'h0D);
    set(OF, 2'h1);
    hold(30);
    chk(tlOpenFwdOut, 2'h2);
    press(OF, 2'h0);
    chk(doorOpen, 2'h1);
    apb(1'b0, pdcl_pkg::OUT_OFS, 32'h0);
    chk(rd[1:0], 2'h1);
    apb(1'b0, pdcl_pkg::IN_HI_OFS, 32'h0);
    chk(rd[11:10], 2'h1);
    press(CF, 2'h1);
    waitfor(1, 1'b0, 1000);
    chk(doorOpen, 2'h0);
  endtask

  task automatic test_done();
    $display("mismatches=%0d comparisons=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    hold(40);
    t_regs();
    t_station();
    t_pax();
    t_key();
    t_ring();
    t_rev();
    test_done();
  end

  // whole sequence needs about 6000 cycles
  initial begin
    #400000;
    err_count++;
    test_done();
  end
endmodule
